// ### src/tmr_compare_waveform.sv
// Purpose: 8-bit timer counter with compare match, waveform generation and pin override
// Assumes: timer_tick is the prescaled clock enable; software strobes are one cycle wide
// Notes: phase-correct mode is not built here; it counts as normal with no output action
//
// Function
// - nonzero compare output mode replaces the port value with compare output state.
// - pin direction stays with the direction bit; output visible only when driving.
// - pin override behaves the same in every waveform mode.
// - compare output mode zero leaves compare output state untouched at a match.
// - a new compare output mode acts from the next compare match.
// - force strobe applies the compare action at once in normal and clear-on-match modes.
// - counting depends on waveform mode only, never on compare output mode.
// - normal mode always increments, rolling from 0xff to 0x00.
// - normal mode sets overflow as counter becomes zero; only software clears it.
// - normal mode accepts a counter write at any time.
// - clear-on-match mode clears the counter when it equals the compare value.
// - clear-on-match compare value is unbuffered; a low value waits for wrap.
// - clear-on-match raises the compare flag every time top is reached.
// - clear-on-match with compare mode one toggles the output at each match.
// - clear-on-match sets overflow when counter passes from max to 0x00.
// - fast PWM counts 0 to 255 and clears on the tick after max.
// - fast PWM mode two clears on match, sets at zero; three is inverse.
// - fast PWM sets overflow each time the counter reaches max.
// - fast PWM mode one toggles at each match; compare value stays buffered.
// - fast PWM max compare gives constant level; zero gives a narrow pulse.
// - a counter equal to compare condition raises the compare flag next tick.
// - compare value direct in non-PWM modes, buffered and loaded at bottom in PWM.
// - forced compare changes output state only, not the flag or the counter.
`timescale 1ns/1ns
module tmr_compare_waveform
   import tmr_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic timer_tick,
   input wire tmr_ctrl_s ctrl,
   input wire tmr_write_s wr,
   input wire logic port_out_value,
   input wire logic compare_pin_direction_bit,
   output logic [7:0] counter_value,
   output logic [7:0] compare_value,
   output logic [7:0] compare_buffer,
   output logic overflow_flag,
   output logic compare_flag,
   output logic compare_output_state,
   output logic compare_output,
   output logic compare_pin_oe_n
);

   logic match_block;
   logic match;
   logic at_max;
   logic pwm_mode;
   logic bottom_load;
   logic next_state;

   // compare output action for a match in the given mode
   function automatic logic match_action(input logic cur, input tmr_com_e com);
      logic res;
      res = cur;
      case (com)
         TMR_COM_TOGGLE: res = ~cur;
         TMR_COM_CLEAR: res = 1'b0;
         TMR_COM_SET: res = 1'b1;
         default: res = cur;
      endcase
      return res;
   endfunction : match_action

   // comparator; a counter write blocks the match for one timer cycle
   assign match = (counter_value == compare_value) && !match_block;
   assign at_max = (counter_value == TMR_MAX);
   assign pwm_mode = (ctrl.waveform_mode == TMR_WAVE_FAST_PWM);
   // max to bottom step in fast PWM, where the buffered compare value lands
   assign bottom_load = timer_tick && pwm_mode && at_max && !wr.counter_wr;

   // counter: software write first, then the mode's count step
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         counter_value <= TMR_COUNT_RST;
      end else if (wr.counter_wr) begin
         counter_value <= wr.counter_data;
      end else if (timer_tick) begin
         case (ctrl.waveform_mode)
            TMR_WAVE_CLEAR_ON_MATCH: begin
               if (match) begin
                  counter_value <= TMR_BOTTOM;
               end else begin
                  counter_value <= counter_value + TMR_ONE;
               end
            end
            TMR_WAVE_FAST_PWM: begin
               if (at_max) begin
                  counter_value <= TMR_BOTTOM;
               end else begin
                  counter_value <= counter_value + TMR_ONE;
               end
            end
            default: counter_value <= counter_value + TMR_ONE;
         endcase
      end
   end

   // match blocking after a counter write, lifted at the next timer tick
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         match_block <= 1'b0;
      end else if (wr.counter_wr) begin
         match_block <= 1'b1;
      end else if (timer_tick) begin
         match_block <= 1'b0;
      end
   end

   // compare value: direct outside PWM, buffered and loaded at bottom in PWM
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         compare_buffer <= TMR_COMPARE_RST;
         compare_value <= TMR_COMPARE_RST;
      end else begin
         if (wr.compare_wr) begin
            compare_buffer <= wr.compare_data;
         end
         if (!pwm_mode && wr.compare_wr) begin
            compare_value <= wr.compare_data;
         end else if (bottom_load) begin
            // late write in the load cycle still lands; avoids a stale period
            compare_value <= wr.compare_wr ? wr.compare_data : compare_buffer;
         end
      end
   end

   // overflow flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
      end else if (timer_tick && !wr.counter_wr && !pwm_mode && at_max) begin
         overflow_flag <= 1'b1;
      end else if (timer_tick && !wr.counter_wr && pwm_mode
                   && counter_value == TMR_MAX - TMR_ONE) begin
         overflow_flag <= 1'b1;
      end else if (wr.overflow_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   // compare flag: set on the tick that ends the matching cycle, never by force
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         compare_flag <= 1'b0;
      end else if (timer_tick && match) begin
         compare_flag <= 1'b1;
      end else if (wr.compare_flag_clear) begin
         compare_flag <= 1'b0;
      end
   end

   // waveform generator next state; mode field read only at the action moment
   always_comb begin
      next_state = compare_output_state;
      if (pwm_mode) begin
         if (timer_tick && match) begin
            next_state = match_action(compare_output_state,
                                      ctrl.compare_output_mode);
         end
         // bottom action after match so max compare holds a constant level
         if (bottom_load) begin
            if (ctrl.compare_output_mode == TMR_COM_CLEAR) begin
               next_state = 1'b1;
            end else if (ctrl.compare_output_mode == TMR_COM_SET) begin
               next_state = 1'b0;
            end
         end
      end else if (ctrl.waveform_mode != TMR_WAVE_PHASE) begin
         if ((timer_tick && match) || wr.force_compare_strobe) begin
            next_state = match_action(compare_output_state,
                                      ctrl.compare_output_mode);
         end
      end
   end

   // compare output state register; kept across mode changes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         compare_output_state <= 1'b0;
      end else begin
         compare_output_state <= next_state;
      end
   end

   // pin override, independent of the waveform mode; one cycle of register delay
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         compare_output <= 1'b0;
         compare_pin_oe_n <= 1'b1;
      end else begin
         if (ctrl.compare_output_mode != TMR_COM_OFF) begin
            compare_output <= compare_output_state;
         end else begin
            compare_output <= port_out_value;
         end
         compare_pin_oe_n <= !compare_pin_direction_bit;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence seq_fast_bottom;
      timer_tick && pwm_mode && at_max && !wr.counter_wr;
   endsequence

   sequence seq_clear_mode;
      ctrl.compare_output_mode == TMR_COM_CLEAR && compare_value != TMR_MAX;
   endsequence

   sequence seq_pwm_match;
      timer_tick && pwm_mode && match;
   endsequence

   pin_override_a: assert property (
      ctrl.compare_output_mode != TMR_COM_OFF |=> compare_output == $past(compare_output_state))
      else $error("compare pin not driven by compare output state");

   pin_direction_a: assert property (
      1'b1 |=> compare_pin_oe_n == !$past(compare_pin_direction_bit))
      else $error("compare pin enable does not follow direction bit");

   mode_zero_a: assert property (
      ctrl.compare_output_mode == TMR_COM_OFF |=> $stable(compare_output_state))
      else $error("compare output state changed with mode zero");

   normal_wrap_a: assert property (
      timer_tick && ctrl.waveform_mode == TMR_WAVE_NORMAL && !wr.counter_wr && at_max
      |=> counter_value == TMR_BOTTOM && overflow_flag)
      else $error("normal mode wrap or overflow wrong");

   clear_top_a: assert property (
      timer_tick && ctrl.waveform_mode == TMR_WAVE_CLEAR_ON_MATCH && !wr.counter_wr && match
      |=> counter_value == TMR_BOTTOM && compare_flag)
      else $error("clear-on-match did not clear or flag");

   clear_toggle_a: assert property (
      timer_tick && ctrl.waveform_mode == TMR_WAVE_CLEAR_ON_MATCH && match
      && ctrl.compare_output_mode == TMR_COM_TOGGLE |=> compare_output_state != $past(compare_output_state))
      else $error("toggle on match missing");

   fast_bottom_a: assert property (
      seq_fast_bottom ##0 seq_clear_mode |=> compare_output_state && counter_value == TMR_BOTTOM)
      else $error("fast PWM bottom did not set output");

   force_quiet_a: assert property (
      wr.force_compare_strobe && !timer_tick && !wr.counter_wr && !compare_flag
      |=> !compare_flag && counter_value == $past(counter_value))
      else $error("force touched flag or counter");

   pwm_buffer_a: assert property (
      wr.compare_wr && pwm_mode && !bottom_load |=> $stable(compare_value))
      else $error("PWM compare value changed outside bottom");

   // step checks of counting, flags and output actions, one clock cycle each
   counter_write_a: assert property (
      wr.counter_wr |=> counter_value == $past(wr.counter_data))
      else $error("counter write did not land");

   flag_next_a: assert property (
      timer_tick && match |=> compare_flag)
      else $error("compare flag not raised after match");

   clear_count_a: assert property (
      timer_tick && ctrl.waveform_mode == TMR_WAVE_CLEAR_ON_MATCH && !wr.counter_wr && !match
      |=> counter_value == $past(counter_value) + TMR_ONE)
      else $error("clear-on-match count step wrong");

   clear_overflow_a: assert property (
      timer_tick && ctrl.waveform_mode == TMR_WAVE_CLEAR_ON_MATCH && !wr.counter_wr && at_max
      |=> overflow_flag)
      else $error("clear-on-match overflow missing");

   fast_count_a: assert property (
      timer_tick && pwm_mode && !wr.counter_wr && !at_max
      |=> counter_value == $past(counter_value) + TMR_ONE)
      else $error("fast PWM count step wrong");

   fast_overflow_a: assert property (
      timer_tick && pwm_mode && !wr.counter_wr && counter_value == TMR_MAX - TMR_ONE
      |=> overflow_flag && at_max)
      else $error("fast PWM overflow not set at max");

   fast_toggle_a: assert property (
      seq_pwm_match ##0 ctrl.compare_output_mode == TMR_COM_TOGGLE
      |=> compare_output_state != $past(compare_output_state))
      else $error("fast PWM toggle on match missing");

   fast_invert_a: assert property (
      seq_fast_bottom ##0 ctrl.compare_output_mode == TMR_COM_SET |=> !compare_output_state)
      else $error("inverting PWM bottom did not clear output");

   pwm_max_a: assert property (
      seq_fast_bottom ##0 seq_pwm_match
      ##0 (compare_value == TMR_MAX && ctrl.compare_output_mode[1])
      |=> compare_output_state == !$past(ctrl.compare_output_mode[0]))
      else $error("max compare did not hold a constant level");

   match_level_a: assert property (
      timer_tick && match && !pwm_mode && ctrl.waveform_mode != TMR_WAVE_PHASE
      && ctrl.compare_output_mode[1]
      |=> compare_output_state == $past(ctrl.compare_output_mode[0]))
      else $error("non-PWM match did not set or clear output");

   force_apply_a: assert property (
      wr.force_compare_strobe && !pwm_mode && ctrl.waveform_mode != TMR_WAVE_PHASE
      && ctrl.compare_output_mode[1]
      |=> compare_output_state == $past(ctrl.compare_output_mode[0]))
      else $error("force strobe did not apply the action");

endmodule : tmr_compare_waveform

// ### src/tmr_pkg.sv
// Purpose: shared constants and carriers for the 8-bit timer compare/waveform block
// Assumes: one clock, counting advanced by a timer tick enable from the prescaler
// Notes: mode encodings follow the two-bit waveform and compare output fields
package tmr_pkg;

   localparam int TMR_WIDTH = 8;
   localparam logic [7:0] TMR_BOTTOM = 8'h00;
   localparam logic [7:0] TMR_MAX = 8'hff;
   localparam logic [7:0] TMR_COUNT_RST = 8'h00;
   localparam logic [7:0] TMR_COMPARE_RST = 8'h00;
   localparam logic [7:0] TMR_ONE = 8'h01;

   // counting sequence selector
   typedef enum logic [1:0] {
      TMR_WAVE_NORMAL = 2'b00,
      TMR_WAVE_PHASE = 2'b01,
      TMR_WAVE_CLEAR_ON_MATCH = 2'b10,
      TMR_WAVE_FAST_PWM = 2'b11
   } tmr_wave_e;

   // compare output action selector
   typedef enum logic [1:0] {
      TMR_COM_OFF = 2'b00,
      TMR_COM_TOGGLE = 2'b01,
      TMR_COM_CLEAR = 2'b10,
      TMR_COM_SET = 2'b11
   } tmr_com_e;

   // software configuration fields
   typedef struct packed {
      tmr_wave_e waveform_mode;
      tmr_com_e compare_output_mode;
   } tmr_ctrl_s;

   // software write strobes with their data
   typedef struct packed {
      logic counter_wr;
      logic [7:0] counter_data;
      logic compare_wr;
      logic [7:0] compare_data;
      logic force_compare_strobe;
      logic overflow_clear;
      logic compare_flag_clear;
   } tmr_write_s;

endpackage : tmr_pkg

// ### tb/tb_tmr_compare_waveform.sv
// Purpose: self-checking bench for the timer compare and waveform block
// Assumes: inputs change on the rising edge by non-blocking assignment
// Notes: outputs are read at the falling edge, once all updates have landed
`timescale 1ns/1ns
module tb_tmr_compare_waveform
   import tmr_pkg::*;
;
   logic clock, nrst, timer_tick, port_out_value, compare_pin_direction_bit, s0;
   tmr_ctrl_s ctrl;
   tmr_write_s wr;
   logic [7:0] counter_value, compare_value, compare_buffer;
   logic overflow_flag, compare_flag, compare_output_state, compare_output, compare_pin_oe_n;
   int err_count = 0;
   int samples_checked = 0;

   tmr_compare_waveform DUT (.clock(clock), .nrst(nrst), .timer_tick(timer_tick), .ctrl(ctrl),
      .wr(wr), .port_out_value(port_out_value),
      .compare_pin_direction_bit(compare_pin_direction_bit), .counter_value(counter_value),
      .compare_value(compare_value), .compare_buffer(compare_buffer),
      .overflow_flag(overflow_flag), .compare_flag(compare_flag),
      .compare_output_state(compare_output_state), .compare_output(compare_output),
      .compare_pin_oe_n(compare_pin_oe_n));

   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task chkb(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask : chkb

   // one-cycle strobe; the write lands at the edge after it is raised
   task put(input tmr_write_s w);
      @(posedge clock);
      wr <= w;
      @(posedge clock);
      wr <= '0;
      @(negedge clock);
   endtask : put

   task wcnt(input logic [7:0] d);
      tmr_write_s w;
      w = '0;
      w.counter_wr = 1'b1;
      w.counter_data = d;
      put(w);
   endtask : wcnt

   task wcmp(input logic [7:0] d);
      tmr_write_s w;
      w = '0;
      w.compare_wr = 1'b1;
      w.compare_data = d;
      put(w);
   endtask : wcmp

   task clrf;
      tmr_write_s w;
      w = '0;
      w.overflow_clear = 1'b1;
      w.compare_flag_clear = 1'b1;
      put(w);
   endtask : clrf

   task frc;
      tmr_write_s w;
      w = '0;
      w.force_compare_strobe = 1'b1;
      put(w);
   endtask : frc

   // n consecutive timer ticks
   task tk(input int n);
      @(posedge clock);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clock);
      timer_tick <= 1'b0;
      @(negedge clock);
   endtask : tk

   // two edges so the registered pin outputs follow the new mode too
   task setc(input tmr_wave_e wm, input tmr_com_e cm);
      @(posedge clock);
      ctrl <= {wm, cm};
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask : setc

   task pin(input logic p, input logic d);
      @(posedge clock);
      port_out_value <= p;
      compare_pin_direction_bit <= d;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask : pin

   task sc_normal;
      setc(TMR_WAVE_NORMAL, TMR_COM_OFF);
      wcnt(8'hfe);
      chk(counter_value, 8'hfe);
      tk(1);
      chkb(overflow_flag, 1'b0);
      tk(1);
      chk(counter_value, 8'h00);
      chkb(overflow_flag, 1'b1);
      tk(1);
      chkb(overflow_flag, 1'b1);
      clrf();
      chkb(overflow_flag, 1'b0);
   endtask : sc_normal

   task sc_clear;
      setc(TMR_WAVE_CLEAR_ON_MATCH, TMR_COM_TOGGLE);
      wcmp(8'h02);
      chk(compare_value, 8'h02);
      wcnt(8'h00);
      clrf();
      s0 = compare_output_state;
      tk(2);
      chkb(compare_flag, 1'b0);
      tk(1);
      chk(counter_value, 8'h00);
      chkb(compare_flag, 1'b1);
      chkb(compare_output_state, ~s0);
      clrf();
      tk(3);
      chkb(compare_flag, 1'b1);
      chkb(compare_output_state, s0);
      // compare value below the count: must run through the wrap first
      wcnt(8'hfe);
      clrf();
      tk(2);
      chk(counter_value, 8'h00);
      chkb(overflow_flag, 1'b1);
      chkb(compare_flag, 1'b0);
   endtask : sc_clear

   task sc_force;
      setc(TMR_WAVE_NORMAL, TMR_COM_SET);
      wcnt(8'h10);
      clrf();
      frc();
      chkb(compare_output_state, 1'b1);
      chk(counter_value, 8'h10);
      chkb(compare_flag, 1'b0);
      setc(TMR_WAVE_NORMAL, TMR_COM_OFF);
      frc();
      chkb(compare_output_state, 1'b1);
      setc(TMR_WAVE_NORMAL, TMR_COM_CLEAR);
      frc();
      chkb(compare_output_state, 1'b0);
   endtask : sc_force

   // port value is the opposite of the compare state so the override shows
   task sc_pin;
      pin(1'b1, 1'b1);
      chkb(compare_pin_oe_n, 1'b0);
      for (int m = 0; m < 4; m++) begin
         setc(tmr_wave_e'(m), TMR_COM_OFF);
         chkb(compare_output, 1'b1);
         setc(tmr_wave_e'(m), TMR_COM_SET);
         chkb(compare_output, 1'b0);
      end
      pin(1'b1, 1'b0);
      chkb(compare_pin_oe_n, 1'b1);
   endtask : sc_pin

   task sc_fast;
      setc(TMR_WAVE_FAST_PWM, TMR_COM_CLEAR);
      wcnt(8'hfd);
      wcmp(8'h80);
      chk(compare_buffer, 8'h80);
      chk(compare_value, 8'h02);
      clrf();
      tk(2);
      chk(counter_value, 8'hff);
      chkb(overflow_flag, 1'b1);
      tk(1);
      chk(counter_value, 8'h00);
      chk(compare_value, 8'h80);
      chkb(compare_output_state, 1'b1);
      wcnt(8'h7e);
      tk(2);
      chkb(compare_output_state, 1'b1);
      tk(1);
      chkb(compare_output_state, 1'b0);
      chkb(compare_flag, 1'b1);
   endtask : sc_fast

   // non-PWM set and clear at match; a new mode waits for the next match
   task sc_match;
      setc(TMR_WAVE_CLEAR_ON_MATCH, TMR_COM_SET);
      wcmp(8'h03);
      wcnt(8'h00);
      tk(4);
      chk(counter_value, 8'h00);
      chkb(compare_output_state, 1'b1);
      setc(TMR_WAVE_CLEAR_ON_MATCH, TMR_COM_CLEAR);
      chkb(compare_output_state, 1'b1);
      tk(4);
      chk(counter_value, 8'h00);
      chkb(compare_output_state, 1'b0);
   endtask : sc_match

   // fast PWM toggle, inverting polarity, force ignored, both extreme compare values
   task sc_wave;
      setc(TMR_WAVE_FAST_PWM, TMR_COM_TOGGLE);
      wcmp(8'h05);
      chk(compare_value, 8'h03);
      wcnt(8'hfe);
      tk(2);
      chk(compare_value, 8'h05);
      chkb(compare_output_state, 1'b0);
      tk(6);
      chkb(compare_output_state, 1'b1);
      setc(TMR_WAVE_FAST_PWM, TMR_COM_SET);
      wcmp(8'h00);
      wcnt(8'hfe);
      tk(2);
      chkb(compare_output_state, 1'b0);
      tk(1);
      chkb(compare_output_state, 1'b1);
      setc(TMR_WAVE_FAST_PWM, TMR_COM_CLEAR);
      frc();
      chkb(compare_output_state, 1'b1);
      wcnt(8'hfe);
      tk(2);
      chkb(compare_output_state, 1'b1);
      tk(1);
      chkb(compare_output_state, 1'b0);
      wcmp(8'hff);
      wcnt(8'hfe);
      tk(2);
      chk(compare_value, 8'hff);
      clrf();
      wcnt(8'hfe);
      tk(2);
      chkb(compare_flag, 1'b1);
      chkb(compare_output_state, 1'b1);
   endtask : sc_wave

   // guard against a hang anywhere in the sequence
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      end_sim();
   end

   initial begin
      nrst = 1'b0;
      timer_tick = 1'b0;
      ctrl = '0;
      wr = '0;
      port_out_value = 1'b0;
      compare_pin_direction_bit = 1'b0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      chk(counter_value, 8'h00);
      chkb(compare_pin_oe_n, 1'b1);
      sc_normal();
      sc_clear();
      sc_force();
      sc_pin();
      sc_fast();
      sc_match();
      sc_wave();
      end_sim();
   end
endmodule : tb_tmr_compare_waveform
